/* File: dacpd_defines.svh */
// Constants of the octal converter power-down and reset control.
// Assumes inclusion by bare name from every file that needs them.
`ifndef DACPD_DEFINES_SVH
`define DACPD_DEFINES_SVH

// ****************************************************************
// Frame commands, top nibble
// ****************************************************************
`define DACPD_CMD_REG_ONLY 4'h8
`define DACPD_CMD_WR_THRU 4'h9
`define DACPD_CMD_PD_HIZ 4'hd
`define DACPD_CMD_PD_100K 4'he
`define DACPD_CMD_PD_2K5 4'hf

// ****************************************************************
// Frame fields
// ****************************************************************
`define DACPD_FRAME_BITS 16
`define DACPD_CMD_MSB 15
`define DACPD_CMD_LSB 12
`define DACPD_ADDR_MSB 14
`define DACPD_ADDR_LSB 12
`define DACPD_DATA_MSB 11
`define DACPD_DATA_LSB 4
`define DACPD_MASK_MSB 7
`define DACPD_MASK_LSB 0

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define DACPD_OFS_CTRL 8'h00
`define DACPD_OFS_STATUS 8'h04
`define DACPD_OFS_CODE_BASE 8'h20
`define DACPD_CTRL_WT_BIT 0
`define DACPD_STAT_PD_LSB 0
`define DACPD_STAT_RECOV_LSB 8
`define DACPD_STAT_BIAS_BIT 16
`define DACPD_STAT_FUNC_BIT 17

// ****************************************************************
// Reset values
// ****************************************************************
`define DACPD_WT_RST 1'b1
`define DACPD_CODE_RST 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define DACPD_CLK_PERIOD_NS 20
`define DACPD_RECOV_MAX_NS 20000
`define DACPD_RECOV_CYC (`DACPD_RECOV_MAX_NS / `DACPD_CLK_PERIOD_NS)
`define DACPD_RAMP_STEP_CYC (`DACPD_RECOV_CYC / 257)

`endif

/* File: dacpd_pkg.sv */
// Types of the octal converter power-down and reset control.
// Assumes nothing beyond a SystemVerilog compiler.
package dacpd_pkg;

   // Channel power state, one-hot
   typedef enum logic [2:0] {
      CH_ACTIVE = 3'b001,
      CH_DOWN = 3'b010,
      CH_RECOV = 3'b100
   } dacpd_ch_state_e;

   // Output termination while powered down
   typedef enum logic [1:0] {
      TERM_NONE = 2'h0,
      TERM_HIZ = 2'h1,
      TERM_100K = 2'h2,
      TERM_2K5 = 2'h3
   } dacpd_term_e;

endpackage

/* File: dacpd_link_rx.sv */
// Serial frame receiver on the link clock.
// Assumes frame select low around 16 rising link-clock edges, data MSB first.
`timescale 1ns/10ps
`include "dacpd_defines.svh"
module dacpd_link_rx (
   // Link side
   input wire logic sclk,
   input wire logic presetn,
   input wire logic sync_n,
   input wire logic din,
   // Toward the control clock domain
   output logic [15:0] frame,
   output logic frame_tgl
);

   logic [14:0] shift;
   logic [4:0] bit_cnt;

   // ****************************************************************
   // Bit counter, cleared by the frame select going high
   // ****************************************************************
   // The link clock stops between frames, so the select clears it directly.
   always_ff @(posedge sclk or negedge presetn or posedge sync_n) begin
      if (!presetn) begin
         bit_cnt <= 5'h00;
      end else if (sync_n) begin
         bit_cnt <= 5'h00;
      end else if (bit_cnt != 5'(`DACPD_FRAME_BITS)) begin
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // ****************************************************************
   // Shift and capture
   // ****************************************************************
   always_ff @(posedge sclk or negedge presetn) begin
      if (!presetn) begin
         shift <= 15'h0000;
      end else if (!sync_n && bit_cnt < 5'(`DACPD_FRAME_BITS - 1)) begin
         shift <= {shift[13:0], din};
      end
   end

   // Bits past the sixteenth are ignored; the word stands until the next frame.
   always_ff @(posedge sclk or negedge presetn) begin
      if (!presetn) begin
         frame <= 16'h0000;
         frame_tgl <= 1'b0;
      end else if (!sync_n && bit_cnt == 5'(`DACPD_FRAME_BITS - 1)) begin
         frame <= {shift, din};
         frame_tgl <= !frame_tgl;
      end
   end

endmodule

/* File: dacpd_ctrl.sv */
// Power-on reset and per-channel power-down control of an octal 8-bit converter.
// Assumes a host sending serial frames and software on APB; zero-wait slave.
// Functional notes
// - Power-on reset clears every channel's input and data registers to zero.
// - Outputs stay at zero until the host writes valid data.
// - Nibbles 1101, 1110, 1111 power down with Hi-Z, 100k, 2.5k termination.
// - Low-byte mask bit n powers down channel n; several at once allowed.
// - Each powered-down channel's core and buffer switch is opened.
// - Shared bias is off only when all eight channels are down.
// - Power-down never changes a channel's stored registers.
// - Serial writes keep working and load registers of powered-down channels.
// - Leaving power-down ramps output from ground to stored value within 20 us.
// - With all channels down, only the reset monitor stays enabled.
// - Nibble 1000 selects register-only writes; 1001 selects write-through.
// - Top bit zero: bits 14-12 pick channel, bits 11-4 carry data.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "dacpd_defines.svh"
module dacpd_ctrl #(
   parameter int NCH = 8,
   parameter int CODE_W = 8
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Serial link
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog control
   output logic [NCH*CODE_W-1:0] dac_code,
   output logic [NCH-1:0] out_valid,
   output logic [NCH-1:0] pd_sw,
   output logic [NCH-1:0] recovering,
   output logic [2*NCH-1:0] term_sel,
   output logic bias_en,
   output logic func_en
);

   if (NCH != 8 || CODE_W != 8 || `DACPD_RAMP_STEP_CYC < 1) begin : g_bad_cfg
      $error("dacpd_ctrl serves eight 8-bit channels with a nonzero ramp step");
   end

   localparam int RECOV_BOUND = `DACPD_RECOV_CYC;

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   function automatic logic is_pd(input logic [3:0] cmd);
      return cmd == `DACPD_CMD_PD_HIZ || cmd == `DACPD_CMD_PD_100K ||
         cmd == `DACPD_CMD_PD_2K5;
   endfunction

   function automatic dacpd_pkg::dacpd_term_e term_of(input logic [3:0] cmd);
      case (cmd)
         `DACPD_CMD_PD_HIZ: return dacpd_pkg::TERM_HIZ;
         `DACPD_CMD_PD_100K: return dacpd_pkg::TERM_100K;
         `DACPD_CMD_PD_2K5: return dacpd_pkg::TERM_2K5;
         default: return dacpd_pkg::TERM_NONE;
      endcase
   endfunction

   // ****************************************************************
   // Link receiver and crossing
   // ****************************************************************
   logic [15:0] link_frame;
   logic link_tgl;
   logic [2:0] sync_ff;
   logic [2:0] tgl_ff;
   logic sync_lvl;
   logic tgl_lvl;
   logic tgl_seen;
   logic sync_rise;
   logic frm_go;

   dacpd_link_rx u_link (
      .sclk(sclk),
      .presetn(presetn),
      .sync_n(sync_n),
      .din(din),
      .frame(link_frame),
      .frame_tgl(link_tgl)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_ff <= 3'h7;
         tgl_ff <= 3'h0;
      end else if (clk_en) begin
         sync_ff <= {sync_ff[1:0], sync_n};
         tgl_ff <= {tgl_ff[1:0], link_tgl};
      end
   end

   // A change counts only once the second and third stages agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_lvl <= 1'b1;
         tgl_lvl <= 1'b0;
         tgl_seen <= 1'b0;
      end else if (clk_en) begin
         if (sync_ff[1] == sync_ff[2]) begin
            sync_lvl <= sync_ff[2];
         end
         if (tgl_ff[1] == tgl_ff[2]) begin
            tgl_lvl <= tgl_ff[2];
         end
         if (sync_rise) begin
            tgl_seen <= tgl_lvl;
         end
      end
   end

   // Short frames never toggle, so their select release decodes nothing.
   assign sync_rise = clk_en && !sync_lvl && sync_ff[1] && sync_ff[2];
   assign frm_go = sync_rise && (tgl_lvl != tgl_seen);

   // Word is stable: it changes only at a 16th bit, long after this point.
   logic [3:0] f_cmd;
   logic [2:0] f_ch;
   logic [7:0] f_data;
   logic [7:0] f_mask;
   logic f_chan;
   logic f_pd;
   assign f_cmd = link_frame[`DACPD_CMD_MSB:`DACPD_CMD_LSB];
   assign f_ch = link_frame[`DACPD_ADDR_MSB:`DACPD_ADDR_LSB];
   assign f_data = link_frame[`DACPD_DATA_MSB:`DACPD_DATA_LSB];
   assign f_mask = link_frame[`DACPD_MASK_MSB:`DACPD_MASK_LSB];
   assign f_chan = frm_go && !link_frame[`DACPD_CMD_MSB];
   assign f_pd = frm_go && is_pd(f_cmd);

   // ****************************************************************
   // Write mode
   // ****************************************************************
   logic wt;
   logic apb_wr;
   assign apb_wr = clk_en && psel && penable && pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wt <= `DACPD_WT_RST;
      end else if (clk_en) begin
         if (frm_go && f_cmd == `DACPD_CMD_REG_ONLY) begin
            wt <= 1'b0;
         end else if (frm_go && f_cmd == `DACPD_CMD_WR_THRU) begin
            wt <= 1'b1;
         end else if (apb_wr && paddr == `DACPD_OFS_CTRL) begin
            wt <= pwdata[`DACPD_CTRL_WT_BIT];
         end
      end
   end

   // ****************************************************************
   // Channel registers and power state
   // ****************************************************************
   logic [CODE_W-1:0] in_reg [NCH];
   logic [CODE_W-1:0] dac_reg [NCH];
   logic [CODE_W-1:0] ramp [NCH];
   dacpd_pkg::dacpd_ch_state_e st [NCH];
   dacpd_pkg::dacpd_ch_state_e next_st [NCH];
   logic [NCH-1:0] hit;
   logic [NCH-1:0] pd_hit;
   logic [NCH-1:0] next_pd;
   logic [9:0] step_cnt;
   logic tick;

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         hit[c] = f_chan && f_ch == 3'(c);
         pd_hit[c] = f_pd && f_mask[c];
         next_st[c] = st[c];
         case (st[c])
            dacpd_pkg::CH_ACTIVE: begin
               if (pd_hit[c]) begin
                  next_st[c] = dacpd_pkg::CH_DOWN;
               end
            end
            dacpd_pkg::CH_DOWN: begin
               if (!pd_hit[c] && hit[c] && wt) begin
                  next_st[c] = dacpd_pkg::CH_RECOV;
               end
            end
            dacpd_pkg::CH_RECOV: begin
               if (pd_hit[c]) begin
                  next_st[c] = dacpd_pkg::CH_DOWN;
               end else if (ramp[c] >= dac_reg[c]) begin
                  next_st[c] = dacpd_pkg::CH_ACTIVE;
               end
            end
            default: next_st[c] = dacpd_pkg::CH_ACTIVE;
         endcase
         next_pd[c] = next_st[c] == dacpd_pkg::CH_DOWN;
      end
   end

   // Power-down touches only state and termination, never the data.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NCH; c++) begin
            in_reg[c] <= `DACPD_CODE_RST;
            dac_reg[c] <= `DACPD_CODE_RST;
         end
         out_valid <= '0;
      end else if (clk_en) begin
         for (int c = 0; c < NCH; c++) begin
            if (hit[c]) begin
               in_reg[c] <= f_data;
            end
            if (hit[c] && wt) begin
               dac_reg[c] <= f_data;
               out_valid[c] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NCH; c++) begin
            st[c] <= dacpd_pkg::CH_ACTIVE;
         end
         term_sel <= '0;
      end else if (clk_en) begin
         for (int c = 0; c < NCH; c++) begin
            st[c] <= next_st[c];
            if (pd_hit[c]) begin
               term_sel[2*c +: 2] <= term_of(f_cmd);
            end else if (next_st[c] != dacpd_pkg::CH_DOWN) begin
               term_sel[2*c +: 2] <= dacpd_pkg::TERM_NONE;
            end
         end
      end
   end

   // ****************************************************************
   // Recovery ramp
   // ****************************************************************
   // One shared divider; 255 steps of this size fit inside the bound.
   assign tick = step_cnt == 10'(`DACPD_RAMP_STEP_CYC - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_cnt <= 10'h000;
      end else if (clk_en) begin
         if (!func_en || tick) begin
            step_cnt <= 10'h000;
         end else begin
            step_cnt <= step_cnt + 10'h001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NCH; c++) begin
            ramp[c] <= `DACPD_CODE_RST;
         end
      end else if (clk_en) begin
         for (int c = 0; c < NCH; c++) begin
            if (st[c] != dacpd_pkg::CH_RECOV) begin
               ramp[c] <= `DACPD_CODE_RST;
            end else if (tick && ramp[c] < dac_reg[c]) begin
               ramp[c] <= ramp[c] + 8'h01;
            end
         end
      end
   end

   // ****************************************************************
   // Analog controls
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_code <= '0;
         bias_en <= 1'b1;
         func_en <= 1'b1;
      end else if (clk_en) begin
         for (int c = 0; c < NCH; c++) begin
            case (st[c])
               dacpd_pkg::CH_RECOV: dac_code[c*CODE_W +: CODE_W] <= ramp[c];
               dacpd_pkg::CH_ACTIVE:
                  dac_code[c*CODE_W +: CODE_W] <= out_valid[c] ? dac_reg[c] : 8'h00;
               default: dac_code[c*CODE_W +: CODE_W] <= 8'h00;
            endcase
         end
         bias_en <= !(&next_pd);
         func_en <= !(&next_pd);
      end
   end

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         pd_sw[c] = st[c] == dacpd_pkg::CH_DOWN;
         recovering[c] = st[c] == dacpd_pkg::CH_RECOV;
      end
   end

   // ****************************************************************
   // APB slave
   // ****************************************************************
   logic [31:0] rd_word;
   logic rd_ok;

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      if (paddr == `DACPD_OFS_CTRL) begin
         rd_word[`DACPD_CTRL_WT_BIT] = wt;
      end else if (paddr == `DACPD_OFS_STATUS) begin
         rd_word[`DACPD_STAT_PD_LSB +: 8] = pd_sw;
         rd_word[`DACPD_STAT_RECOV_LSB +: 8] = recovering;
         rd_word[`DACPD_STAT_BIAS_BIT] = bias_en;
         rd_word[`DACPD_STAT_FUNC_BIT] = func_en;
      end else if (paddr[7:5] == 3'(`DACPD_OFS_CODE_BASE >> 5) && paddr[1:0] == 2'h0) begin
         rd_word[7:0] = in_reg[paddr[4:2]];
      end else begin
         rd_ok = 1'b0;
      end
   end

   // Answer is prepared in the setup cycle; the access cycle completes at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clk_en && psel && !penable) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_word;
         pslverr <= !rd_ok;
      end
   end

   assign pready = clk_en;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_por_clear;
      @(posedge pclk) disable iff (!presetn)
         $rose(presetn) |-> dac_code == '0 && in_reg[0] == 8'h00 && dac_reg[7] == 8'h00;
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("Registers not cleared");

   property p_zero_until_data;
      @(posedge pclk) disable iff (!presetn)
         !out_valid[0] |=> dac_code[7:0] == 8'h00;
   endproperty
   a_zero_until_data: assert property (p_zero_until_data) else $error("Output before data");

   property p_pd_hiz;
      @(posedge pclk) disable iff (!presetn)
         f_pd && f_cmd == `DACPD_CMD_PD_HIZ && f_mask[0] |=>
            pd_sw[0] && term_sel[1:0] == dacpd_pkg::TERM_HIZ;
   endproperty
   a_pd_hiz: assert property (p_pd_hiz) else $error("Hi-Z power-down missed");

   property p_mask_only;
      @(posedge pclk) disable iff (!presetn)
         f_pd && !f_mask[3] && !pd_sw[3] |=> !pd_sw[3];
   endproperty
   a_mask_only: assert property (p_mask_only) else $error("Unmasked channel powered down");

   property p_bias_all;
      @(posedge pclk) disable iff (!presetn)
         clk_en |=> bias_en == !(&pd_sw) && func_en == bias_en;
   endproperty
   a_bias_all: assert property (p_bias_all) else $error("Bias or gate mismatch");

   property p_pd_keeps;
      @(posedge pclk) disable iff (!presetn)
         f_pd |=> $stable(dac_reg[2]) && $stable(in_reg[2]);
   endproperty
   a_pd_keeps: assert property (p_pd_keeps) else $error("Power-down changed data");

   property p_write_while_down;
      @(posedge pclk) disable iff (!presetn)
         hit[1] && pd_sw[1] |=> in_reg[1] == $past(f_data);
   endproperty
   a_write_while_down: assert property (p_write_while_down) else $error("Write lost");

   property p_recover_bound;
      @(posedge pclk) disable iff (!presetn)
         $rose(recovering[1]) && clk_en |-> ##[1:RECOV_BOUND] !recovering[1] || !clk_en;
   endproperty
   a_recover_bound: assert property (p_recover_bound) else $error("Recovery too slow");

   property p_wrm_holds;
      @(posedge pclk) disable iff (!presetn)
         hit[1] && !wt |=> $stable(dac_reg[1]);
   endproperty
   a_wrm_holds: assert property (p_wrm_holds) else $error("Register mode moved output");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
         hit[1] && wt && pd_sw[1] |=> recovering[1] && dac_reg[1] == $past(f_data);
   endproperty
   a_wake: assert property (p_wake) else $error("Channel did not wake");

endmodule

/* File: dacpd_host_model.sv */
// Host controller model driving the serial command link.
// Assumes the bench calls send_frame; nothing else drives the link pins.
`timescale 1ns/10ps
module dacpd_host_model (
   // Serial link
   output logic sclk,
   output logic sync_n,
   output logic din
);
   // Idle levels for lowest device current
   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      din = 1'b0;
   end

   // ****************************************************************
   // Frame transmit
   // ****************************************************************
   // Odd start offset keeps the link clock unrelated in phase to pclk
   task automatic send_frame(input logic [15:0] f);
      #7.3;
      sync_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         din = f[i];
         #31.25 sclk = 1'b1;
         #62.5 sclk = 1'b0;
         #31.25;
      end
      sync_n = 1'b1;
      din = 1'b0;
      #200;
   endtask
endmodule

/* File: dac_octal_powerdown_por_ctrl_tb_top.sv */
// Self-checking bench for the converter power-down and reset control.
// Assumes a host model on the link and an APB master in this module.
`timescale 1ns/10ps
module dac_octal_powerdown_por_ctrl_tb_top;
   logic pclk;
   logic presetn;
   logic clk_en;
   logic sclk, sync_n, din;
   logic psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, er, bias_en, func_en;
   logic [63:0] dac_code, exp_code;
   logic [7:0] out_valid, pd_sw, recovering, v;
   logic [15:0] term_sel;
   int err_total = 0;
   int check_count = 0;
   int n;

   dacpd_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .sclk(sclk),
      .sync_n(sync_n), .din(din), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dac_code(dac_code), .out_valid(out_valid), .pd_sw(pd_sw),
      .recovering(recovering), .term_sel(term_sel), .bias_en(bias_en),
      .func_en(func_en));
   dacpd_host_model host (.sclk(sclk), .sync_n(sync_n), .din(din));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Trailing edge keeps back-to-back calls from assigning psel twice
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic frame(input logic [15:0] f);
      host.send_frame(f);
      repeat (4) @(posedge pclk);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #500000;
      err_total++;
      $display("FAIL t=%0t watchdog expired", $time);
      summarize();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(dac_code, 64'h0);
      chk(out_valid, 8'h00);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0003_0000);
      for (int c = 0; c < 8; c++) begin
         apb(1'b0, 8'h20 + 8'(4 * c), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, 8'h10, 32'h0);
      chk({er, rd}, 33'h1_0000_0000);
      apb(1'b1, 8'h04, 32'hffff_ffff);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0003_0000);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
      $display("test reset_and_registers done");

      for (int c = 0; c < 8; c++) begin
         v = 8'(17 * (c + 1));
         exp_code[8*c+:8] = v;
         frame({1'b0, 3'(c), v, 4'h0});
      end
      chk(dac_code, exp_code);
      chk(out_valid, 8'hff);
      $display("test write_through done");

      // Bits 11..8 nonzero must not matter
      frame({4'hd, 4'ha, 8'h05});
      chk(pd_sw, 8'h05);
      chk(term_sel, 16'h0011);
      chk(bias_en, 1'b1);
      chk(dac_code, exp_code & 64'hffff_ffff_ff00_ff00);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h11);
      for (int m = 0; m < 3; m++) begin
         frame({4'hd + 4'(m), 4'h0, 8'hff});
         chk(term_sel, {8{2'(m + 1)}});
         chk(pd_sw, 8'hff);
         chk({bias_en, func_en}, 2'b00);
      end
      $display("test power_down done");

      frame(16'h8000);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      frame({4'h1, 8'h5a, 4'h0});
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h5a);
      chk(pd_sw, 8'hff);
      frame(16'h9000);
      frame({4'h1, 8'hc3, 4'h0});
      chk(recovering, 8'h02);
      chk({bias_en, func_en}, 2'b11);
      chk(dac_code[15:8] < 8'hc3, 1'b1);
      // Enable low must hold the ramp and drop the bus answer
      clk_en <= 1'b0;
      @(posedge pclk);
      v = dac_code[15:8];
      repeat (20) @(posedge pclk);
      chk(dac_code[15:8], v);
      chk({pready, recovering[1]}, 2'b01);
      clk_en <= 1'b1;
      n = 0;
      while (recovering[1] !== 1'b0 && n < 985) begin
         @(posedge pclk);
         n++;
      end
      chk(n < 985, 1'b1);
      repeat (2) @(posedge pclk);
      chk(dac_code[15:8], 8'hc3);
      chk(pd_sw, 8'hfd);
      $display("test recovery done");

      // Second reset with data loaded must clear it all again
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(dac_code, 64'h0);
      chk({out_valid, pd_sw}, 16'h0000);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h0);
      $display("test reset_again done");
      summarize();
   end
endmodule
